// ### verilog/nvsi_pkg.sv
// Shared constants and types for the serial nonvolatile SRAM slave port.
// Assumes a single system clock; all bus pins are asynchronous to it.
package nvsi_pkg;

  // ==========================================================================
  // Geometry and selection codes
  localparam int MEM_AW = 17;
  localparam int SYNC_W = 5;
  localparam logic [3:0] MEM_NIBBLE = 4'h_A;
  localparam logic [3:0] CTRL_NIBBLE = 4'h_3;
  localparam logic [4:0] HS_MASTER_CODE = 5'h_01;

  // ==========================================================================
  // Control space offsets
  localparam logic [7:0] REG_LOCK = 8'h_00;
  localparam logic [7:0] REG_SERIAL_FIRST = 8'h_01;
  localparam logic [7:0] REG_SERIAL_LAST = 8'h_08;
  localparam logic [7:0] REG_IDENT_FIRST = 8'h_09;
  localparam logic [7:0] REG_IDENT_LAST = 8'h_0C;
  localparam logic [7:0] REG_RESERVED = 8'h_0D;
  localparam logic [7:0] REG_COMMAND = 8'h_AA;

  // ==========================================================================
  // Lock register fields and reset values
  localparam int LOCK_BIT = 6;
  localparam int PROT_HI_BIT = 3;
  localparam int PROT_LO_BIT = 2;
  localparam logic [7:0] LOCK_RESET = 8'h_00;
  localparam logic [1:0] PROT_NONE = 2'h_0;
  localparam logic [1:0] PROT_QUARTER = 2'h_1;
  localparam logic [1:0] PROT_HALF = 2'h_2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h_8;

  // ==========================================================================
  // Types
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_RX   = 6'b00_0010,
    ST_ACKO = 6'b00_0100,
    ST_TX   = 6'b00_1000,
    ST_ACKI = 6'b01_0000,
    ST_WAIT = 6'b10_0000
  } nvsi_state_t;

  typedef struct packed {
    logic [1:0] board_select_pins;
    logic write_protect;
    logic sda;
    logic scl;
  } nvsi_pins_t;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } nvsi_cmd_t;

endpackage : nvsi_pkg

// ### verilog/nvsi_slave.sv
// Two-wire slave front end with memory array and control register space.
// Assumes SCL, SDA, write protect and board select arrive asynchronously.
`timescale 1ns/1ps

// Summary of operation
// (R1) Rising SDA with SCL high ends transaction.
// (R2) Bus busy from START until STOP.
// (R3) Repeated START restarts at slave address byte.
// (R4) Bytes MSB first, each acknowledged.
// (R5) Drive SDA changes only while SCL low.
// (R6) Release SDA after byte; receiver pulls ack.
// (R7) Not-acknowledge aborts the current operation.
// (R8) Master not-acknowledge on read releases SDA.
// (R9) Writes to protected places are not-acknowledged.
// (R10) Master code then no-ack enters high speed.
// (R11) High speed kept over repeated START, STOP exits.
// (R12) First byte: seven address bits plus direction.
// (R13) Nibble 1010 selects memory, bit1 top address.
// (R14) Nibble 0011 selects control space, bit1 ignored.
// (R15) Address is 17 bits, two bytes low.
// (R16) Control space map: lock, serial, ident, command.
// (R17) Lock register: lock bit 6, protect 3:2.
// (R18) Protect bits writable at control offset zero.
// (R19) Protection never blocks nonvolatile store copy.
// (R20) Serial lock sets once, locks serial bytes.
// (R21) Write protect pin rejects writes, freezes address.
// (R22) Address advances each byte and wraps to zero.
// (R23) Reads use current address; address-only write sets.
// (R24) Unmatched slave byte: no ack, ignore until restart.
// (R25) Protect levels: none, quarter, half, whole array.
module nvsi_slave #(
  parameter logic [31:0] IDENT_WORD = 32'h_1234_5678
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Bus pins and straps
  input wire nvsi_pkg::nvsi_pins_t pins_i,
  output logic sda_o,
  output logic sda_oe,
  // Status and command issue
  output logic hs_mode,
  output logic bus_busy,
  output nvsi_pkg::nvsi_cmd_t cmd_o
);
  import nvsi_pkg::*;

  // ==========================================================================
  // State record
  typedef struct packed {
    logic [SYNC_W-1:0] s0;
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] stab;
    nvsi_state_t st;
    logic [3:0] bit_cnt;
    logic [1:0] byte_idx;
    logic [7:0] shreg;
    logic is_ctrl;
    logic rw;
    logic adv;
    logic nack;
    logic [MEM_AW-1:0] mem_addr;
    logic [7:0] reg_ptr;
    logic hs;
    logic busy;
    logic oe;
    logic serial_lock_flag;
    logic [1:0] protect_level_field;
    logic [7:0][7:0] serial;
    nvsi_cmd_t cmd;
  } nvsi_regs_t;

  localparam logic [SYNC_W-1:0] PIN_IDLE = 5'h_03;

  localparam nvsi_regs_t RESET = '{
    st: ST_IDLE,
    s0: PIN_IDLE,
    s1: PIN_IDLE,
    s2: PIN_IDLE,
    stab: PIN_IDLE,
    default: '0
  };

  nvsi_regs_t q;
  nvsi_regs_t d;
  logic [7:0] mem [0:(1 << MEM_AW) - 1];
  logic mem_we;
  logic [7:0] mem_wdata;
  logic [SYNC_W-1:0] agree;
  logic [SYNC_W-1:0] stab_new;
  logic scl_new;
  logic sda_new;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic data_ph;
  logic prot_hit;
  logic [MEM_AW-1:0] addr_inc;
  logic [7:0] ptr_inc;
  logic [7:0] rd_cur;
  logic [7:0] rd_nxt;
  logic [7:0] rx_byte;

  // ==========================================================================
  // Read source for the transmit shifter
  function automatic logic [7:0] rd_byte(input logic ctrl,
                                         input logic [MEM_AW-1:0] a,
                                         input logic [7:0] p,
                                         input nvsi_regs_t r);
    logic [7:0] v;
    v = 8'h_00;
    if (!ctrl) begin
      v = mem[a];
    end else if (p == REG_LOCK) begin
      v[LOCK_BIT] = r.serial_lock_flag; // R17
      v[PROT_HI_BIT:PROT_LO_BIT] = r.protect_level_field; // R17
    end else if (p >= REG_SERIAL_FIRST && p <= REG_SERIAL_LAST) begin
      v = r.serial[3'(p - REG_SERIAL_FIRST)]; // R16
    end else if (p >= REG_IDENT_FIRST && p <= REG_IDENT_LAST) begin
      v = IDENT_WORD[8 * (p - REG_IDENT_FIRST) +: 8]; // R16
    end
    return v;
  endfunction : rd_byte

  // ==========================================================================
  // Next-state logic
  always_comb begin
    d = q;
    mem_we = 1'b0;
    mem_wdata = q.shreg;
    d.cmd.valid = 1'b0;
    d.s0 = pins_i;
    d.s1 = q.s0;
    d.s2 = q.s1;
    agree = ~(q.s1 ^ q.s2);
    stab_new = (agree & q.s2) | (~agree & q.stab);
    d.stab = stab_new;
    scl_new = stab_new[0];
    sda_new = stab_new[1];
    scl_rise = scl_new & ~q.stab[0];
    scl_fall = ~scl_new & q.stab[0];
    start_ev = q.stab[0] & scl_new & q.stab[1] & ~sda_new;
    stop_ev = q.stab[0] & scl_new & ~q.stab[1] & sda_new; // R1
    addr_inc = q.mem_addr + MEM_AW'(1); // R22
    ptr_inc = q.reg_ptr + 8'h_01;
    rd_cur = rd_byte(q.is_ctrl, q.mem_addr, q.reg_ptr, q);
    rd_nxt = rd_byte(q.is_ctrl, addr_inc, ptr_inc, q);
    rx_byte = q.shreg;
    data_ph = q.is_ctrl ? (q.byte_idx >= 2'd2) : (q.byte_idx == 2'd3);
    unique case (q.protect_level_field) // R25
      PROT_NONE: prot_hit = 1'b0;
      PROT_QUARTER: prot_hit = &q.mem_addr[MEM_AW-1:MEM_AW-2];
      PROT_HALF: prot_hit = q.mem_addr[MEM_AW-1];
      default: prot_hit = 1'b1;
    endcase
    if (stop_ev) begin
      d.st = ST_IDLE; // R1
      d.busy = 1'b0; // R2
      d.hs = 1'b0; // R11
      d.oe = 1'b0;
    end else if (start_ev) begin
      d.st = ST_RX; // R3
      d.busy = 1'b1; // R2
      d.oe = 1'b0;
      d.bit_cnt = '0;
      d.byte_idx = '0;
      d.rw = 1'b0;
      d.adv = 1'b0;
    end else begin
      unique case (q.st)
        ST_IDLE, ST_WAIT: begin
          d.oe = 1'b0; // R24
        end
        ST_RX: begin
          if (scl_rise) begin
            d.shreg = {q.shreg[6:0], sda_new}; // R4
            d.bit_cnt = q.bit_cnt + 4'h_1;
          end else if (scl_fall && q.bit_cnt == BITS_PER_BYTE) begin
            // Decide the acknowledge while SCL is low.
            d.st = ST_ACKO;
            d.oe = 1'b1; // R6
            d.adv = 1'b0;
            if (q.byte_idx != 2'd3) begin
              d.byte_idx = q.byte_idx + 2'd1;
            end
            if (q.byte_idx == 2'd0) begin
              d.rw = rx_byte[0]; // R12
              if (rx_byte[7:3] == HS_MASTER_CODE) begin
                d.hs = 1'b1; // R10
                d.oe = 1'b0;
                d.st = ST_WAIT;
              end else if (rx_byte[7:4] == MEM_NIBBLE &&
                  rx_byte[3:2] == q.stab[4:3]) begin
                d.is_ctrl = 1'b0; // R13
                d.mem_addr[MEM_AW-1] = rx_byte[1]; // R15
              end else if (rx_byte[7:4] == CTRL_NIBBLE &&
                  rx_byte[3:2] == q.stab[4:3]) begin
                d.is_ctrl = 1'b1; // R14
              end else begin
                d.oe = 1'b0; // R24
                d.st = ST_WAIT;
              end
            end else if (!data_ph) begin
              if (q.is_ctrl) begin
                d.reg_ptr = rx_byte;
              end else if (q.byte_idx == 2'd1) begin
                d.mem_addr[15:8] = rx_byte; // R15
              end else begin
                d.mem_addr[7:0] = rx_byte; // R23
              end
            end else if (q.stab[2]) begin
              d.oe = 1'b0; // R21
              d.st = ST_WAIT;
            end else if (!q.is_ctrl) begin
              if (prot_hit) begin
                d.oe = 1'b0; // R9
                d.st = ST_WAIT;
              end else begin
                mem_we = 1'b1;
                d.adv = 1'b1;
              end
            end else begin
              d.adv = 1'b1;
              if (q.reg_ptr == REG_LOCK) begin
                d.protect_level_field =
                  rx_byte[PROT_HI_BIT:PROT_LO_BIT]; // R18
                d.serial_lock_flag =
                  q.serial_lock_flag | rx_byte[LOCK_BIT]; // R20
              end else if (q.reg_ptr >= REG_SERIAL_FIRST &&
                  q.reg_ptr <= REG_SERIAL_LAST && !q.serial_lock_flag) begin
                d.serial[3'(q.reg_ptr - REG_SERIAL_FIRST)] = rx_byte;
              end else if (q.reg_ptr == REG_COMMAND) begin
                d.cmd.valid = 1'b1; // R16
                d.cmd.code = rx_byte;
              end else begin
                d.oe = 1'b0; // R9
                d.st = ST_WAIT;
                d.adv = 1'b0;
              end
            end
          end
        end
        ST_ACKO: begin
          if (scl_fall) begin
            d.bit_cnt = '0;
            d.adv = 1'b0;
            if (q.adv && !q.stab[2]) begin // R21
              if (q.is_ctrl) begin
                d.reg_ptr = ptr_inc;
              end else begin
                d.mem_addr = addr_inc; // R22
              end
            end
            if (q.rw) begin
              d.st = ST_TX;
              d.shreg = rd_cur; // R23
              d.oe = ~rd_cur[7]; // R5
            end else begin
              d.st = ST_RX;
              d.oe = 1'b0; // R6
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            d.bit_cnt = q.bit_cnt + 4'h_1;
          end else if (scl_fall) begin
            if (q.bit_cnt == BITS_PER_BYTE) begin
              d.st = ST_ACKI;
              d.oe = 1'b0; // R6
            end else begin
              d.shreg = {q.shreg[6:0], 1'b0};
              d.oe = ~q.shreg[6]; // R4
            end
          end
        end
        ST_ACKI: begin
          if (scl_rise) begin
            if (sda_new) begin
              d.st = ST_WAIT; // R7 R8
              if (q.is_ctrl) begin
                d.reg_ptr = ptr_inc;
              end else begin
                d.mem_addr = addr_inc; // R22
              end
            end
          end else if (scl_fall) begin
            d.bit_cnt = '0;
            if (q.is_ctrl) begin
              d.reg_ptr = ptr_inc;
            end else begin
              d.mem_addr = addr_inc; // R22
            end
            d.shreg = rd_nxt;
            d.oe = ~rd_nxt[7];
            d.st = ST_TX;
          end
        end
        default: begin
          d.st = ST_IDLE;
          d.oe = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Registers and memory array
  always_ff @(posedge mclk) begin
    if (srst) begin
      q <= RESET;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem[q.mem_addr] <= mem_wdata; // R19
    end
  end

  assign sda_o = q.nack;
  assign sda_oe = q.oe;
  assign hs_mode = q.hs;
  assign bus_busy = q.busy;
  assign cmd_o = q.cmd;

  // ==========================================================================
  // Checks
  property p_stop_ends;
    @(posedge mclk) disable iff (srst)
      stop_ev |=> (q.st == ST_IDLE) && !q.busy && !q.oe;
  endproperty
  a_stop_ends: assert property (p_stop_ends) // R1
    else $error("stop did not end transaction");

  property p_start_busy;
    @(posedge mclk) disable iff (srst)
      start_ev && !stop_ev |=> q.busy && q.st == ST_RX && q.byte_idx == 2'd0;
  endproperty
  a_start_busy: assert property (p_start_busy) // R3
    else $error("start did not restart address phase");

  property p_hs_kept;
    @(posedge mclk) disable iff (srst)
      q.hs && start_ev |=> q.hs;
  endproperty
  a_hs_kept: assert property (p_hs_kept) // R11
    else $error("high speed lost on repeated start");

  property p_hs_exit;
    @(posedge mclk) disable iff (srst)
      stop_ev |=> !q.hs ##1 !q.hs || start_ev;
  endproperty
  a_hs_exit: assert property (p_hs_exit) // R11
    else $error("high speed kept after stop");

  property p_read_nack;
    @(posedge mclk) disable iff (srst)
      q.st == ST_ACKI && scl_rise && sda_new && !start_ev && !stop_ev
      |=> q.st == ST_WAIT && !q.oe;
  endproperty
  a_read_nack: assert property (p_read_nack) // R8
    else $error("sda held after master no-ack");

  property p_wp_blocks;
    @(posedge mclk) disable iff (srst)
      q.stab[2] && q.st == ST_RX |-> !mem_we && !d.adv;
  endproperty
  a_wp_blocks: assert property (p_wp_blocks) // R21
    else $error("write accepted under write protect");

  property p_lock_sticky;
    @(posedge mclk) disable iff (srst)
      q.serial_lock_flag |=> q.serial_lock_flag && $stable(q.serial);
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) // R20
    else $error("serial lock cleared or serial changed");

  property p_prot_blocks;
    @(posedge mclk) disable iff (srst)
      mem_we |-> !prot_hit;
  endproperty
  a_prot_blocks: assert property (p_prot_blocks) // R25
    else $error("protected byte written");

  property p_oe_on_low;
    @(posedge mclk) disable iff (srst)
      $changed(q.oe) && q.st != ST_WAIT && q.st != ST_IDLE
      && !$past(stop_ev) && !$past(start_ev) |-> !q.stab[0];
  endproperty
  a_oe_on_low: assert property (p_oe_on_low) // R5
    else $error("sda drive changed while scl high");

endmodule : nvsi_slave

// ### tb/nvsi_master_model.sv
// Bus master model for the two-wire slave port: starts, stops and bytes.
// Assumes the bench resolves SDA as a pulled-up open-drain wire.
`timescale 1ns/1ps
module nvsi_master_model (
  // Wire side
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  logic qtick;

  // ==========================================================================
  // Quarter-bit timer, 125 ns per bit, clear of the system clock edges.
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    qtick = 1'b0;
    #1.0;
    forever #31.25 qtick = ~qtick;
  end

  task automatic step();
    @(qtick);
  endtask : step

  // ==========================================================================
  // Bit, start, stop and byte cycles.
  task automatic bit_io(input logic v, output logic seen);
    sda_pull = ~v;
    step();
    scl = 1'b1;
    step();
    seen = sda;
    step();
    scl = 1'b0;
    step();
  endtask : bit_io

  task automatic start();
    sda_pull = 1'b0;
    step();
    scl = 1'b1;
    step();
    sda_pull = 1'b1;
    step();
    scl = 1'b0;
    step();
  endtask : start

  task automatic stop();
    sda_pull = 1'b1;
    step();
    scl = 1'b1;
    step();
    sda_pull = 1'b0;
    step();
    step();
  endtask : stop

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask : send_byte

  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(~ack, s);
  endtask : recv_byte
endmodule : nvsi_master_model

// ### tb/nvsi_slave_tb_top.sv
// Self-checking bench for the two-wire slave port of the serial memory.
// Assumes the master model file and the design package are compiled first.
`timescale 1ns/1ps
module nvsi_slave_tb_top;
  import nvsi_pkg::*;
  localparam logic [31:0] IDENT = 32'h_A1B2_C3D4; // Arbitrary value.
  localparam logic [1:0] BSEL = 2'h_2;
  localparam int LIMIT = 60000;
  localparam logic [3:0][16:0] PFIRST = {17'h_0_0000, 17'h_1_0000,
    17'h_1_8000, 17'h_1_FFFF};
  logic mclk;
  logic srst;
  logic wp;
  logic [1:0] bsp;
  logic scl;
  logic sda_pull;
  logic sda_wire;
  nvsi_pins_t pins;
  logic sda_o;
  logic sda_oe;
  logic hs_mode;
  logic bus_busy;
  nvsi_cmd_t cmd;
  logic oe_prev = 1'b0;
  logic hs_ack;
  logic [7:0] cmd_seen;
  logic [7:0] rb [4];
  logic [5:0] ak;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  int cmd_count = 0;

  assign sda_wire = ~(sda_pull | (sda_oe & ~sda_o));
  assign pins = {bsp, wp, sda_wire, scl};

  nvsi_slave #(.IDENT_WORD(IDENT)) nvsi_slave_i (
    .mclk(mclk), .srst(srst), .pins_i(pins), .sda_o(sda_o),
    .sda_oe(sda_oe), .hs_mode(hs_mode), .bus_busy(bus_busy), .cmd_o(cmd)
  );
  nvsi_master_model nvsi_master_model_i (
    .scl(scl), .sda_pull(sda_pull), .sda(sda_wire)
  );

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // ==========================================================================
  // Checking and closing.
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic conclude();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    oe_prev <= sda_oe;
    if (cmd.valid === 1'b1 && srst === 1'b0) begin
      cmd_count <= cmd_count + 1;
      cmd_seen <= cmd.code;
    end
    if (sda_oe === 1'b1 && oe_prev === 1'b0 && scl === 1'b1) begin
      chk("sda_hold", 1'b0, 1'b1);
    end
    if (cycles == LIMIT) begin
      miscompares++;
      conclude();
    end
  end

  // ==========================================================================
  // Transfers.
  function automatic logic [7:0] msb(input logic a16, input logic r);
    return {MEM_NIBBLE, BSEL, a16, r};
  endfunction : msb

  function automatic logic [7:0] csb(input logic r);
    return {CTRL_NIBBLE, BSEL, 1'b1, r};
  endfunction : csb

  task automatic wr(input logic [7:0] sb, input logic [39:0] by,
      input int n, input logic fin);
    logic a;
    nvsi_master_model_i.start();
    nvsi_master_model_i.send_byte(sb, a);
    ak = {5'h_00, a};
    for (int i = 0; i < n; i++) begin
      nvsi_master_model_i.send_byte(by[39-8*i -: 8], a);
      ak[i+1] = a;
    end
    if (fin) begin
      nvsi_master_model_i.stop();
    end
  endtask : wr

  task automatic rd(input logic [7:0] sb, input int n);
    logic a;
    nvsi_master_model_i.start();
    nvsi_master_model_i.send_byte(sb, a);
    ak = {5'h_00, a};
    for (int i = 0; i < n; i++) begin
      nvsi_master_model_i.recv_byte(i != n - 1, rb[i]);
    end
    nvsi_master_model_i.stop();
  endtask : rd

  task automatic mem_wr1(input logic [16:0] ad, input logic [7:0] d);
    wr(msb(ad[16], 1'b0), {ad[15:0], d, 16'h_0000}, 3, 1'b1);
  endtask : mem_wr1

  task automatic creg_wr(input logic [7:0] off, input logic [7:0] v);
    wr(csb(1'b0), {off, v, 24'h_00_0000}, 2, 1'b1);
  endtask : creg_wr

  task automatic creg_rd(input logic [7:0] off);
    wr(csb(1'b0), {off, 32'h_0000_0000}, 1, 1'b0);
    rd(csb(1'b1), 1);
  endtask : creg_rd

  // ==========================================================================
  // Test sequence.
  initial begin
    srst = 1'b1;
    wp = 1'b0;
    bsp = BSEL;
    repeat (2) @(negedge mclk);
    srst = 1'b0;
    repeat (8) @(negedge mclk);
    chk("busy", 1'b0, bus_busy);
    chk("oe", 1'b0, sda_oe);
    wr(msb(1'b1, 1'b0), 40'h_FF_FF5A_C396, 5, 1'b0);
    chk("busy", 1'b1, bus_busy);
    chk("acks", 6'h_3F, ak);
    nvsi_master_model_i.stop();
    chk("busy", 1'b0, bus_busy);
    wr(msb(1'b1, 1'b0), 40'h_FF_FF00_0000, 2, 1'b0);
    rd(msb(1'b1, 1'b1), 2);
    chk("rd0", 8'h_5A, rb[0]);
    chk("rd1", 8'h_C3, rb[1]);
    rd(msb(1'b0, 1'b1), 1);
    chk("rd_cur", 8'h_96, rb[0]);
    wr({MEM_NIBBLE, ~BSEL, 2'h_0}, 40'h_00_0000_0000, 1, 1'b1);
    chk("bsel_nack", 6'h_00, ak);
    wr(8'h_50, 40'h_00_0000_0000, 1, 1'b1);
    chk("sel_nack", 6'h_00, ak);
    creg_rd(REG_LOCK);
    chk("lock_rst", LOCK_RESET, rb[0]);
    creg_wr(REG_SERIAL_FIRST, 8'h_77);
    chk("sn_ack", 1'b1, ak[2]);
    creg_wr(REG_LOCK, 8'h_FF);
    creg_rd(REG_LOCK);
    chk("lock", 8'h_4C, rb[0]);
    creg_wr(REG_LOCK, 8'h_00);
    creg_rd(REG_LOCK);
    chk("lock_kept", 8'h_40, rb[0]);
    creg_wr(REG_SERIAL_FIRST, 8'h_88);
    chk("sn_nack", 1'b0, ak[2]);
    creg_rd(REG_SERIAL_FIRST);
    chk("sn", 8'h_77, rb[0]);
    for (int i = 0; i < 4; i++) begin
      creg_rd(REG_IDENT_FIRST + 8'(i));
      chk("ident", IDENT[8*i +: 8], rb[0]);
    end
    creg_wr(REG_IDENT_FIRST, 8'h_00);
    chk("id_nack", 1'b0, ak[2]);
    creg_rd(REG_RESERVED);
    chk("rsvd", 8'h_00, rb[0]);
    creg_wr(REG_COMMAND, 8'h_3C);
    chk("cmd_n", 1, cmd_count);
    chk("cmd", 8'h_3C, cmd_seen);
    for (int l = 0; l < 4; l++) begin
      creg_wr(REG_LOCK, {4'h_0, l[1:0], 2'h_0});
      mem_wr1(PFIRST[l] - 17'h_0_0001, 8'h_E7);
      chk("prot_below", l < 3, ak[3]);
      mem_wr1(PFIRST[l], 8'h_E7);
      chk("prot_first", l == 0, ak[3]);
    end
    creg_wr(REG_LOCK, 8'h_00);
    wr(msb(1'b0, 1'b0), 40'h_00_0000_0000, 2, 1'b0);
    rd(msb(1'b0, 1'b1), 1);
    chk("prot_keep", 8'h_C3, rb[0]);
    mem_wr1(17'h_0_0100, 8'h_11);
    @(negedge mclk);
    wp = 1'b1;
    mem_wr1(17'h_0_0100, 8'h_22);
    chk("wp_acks", 6'h_07, ak);
    creg_wr(REG_LOCK, 8'h_0C);
    chk("wp_reg", 1'b0, ak[2]);
    @(negedge mclk);
    wp = 1'b0;
    rd(msb(1'b0, 1'b1), 1);
    chk("wp_addr", 8'h_11, rb[0]);
    nvsi_master_model_i.start();
    nvsi_master_model_i.send_byte({HS_MASTER_CODE, 3'h_5}, hs_ack);
    chk("mcode_nack", 1'b0, hs_ack);
    chk("hs_on", 1'b1, hs_mode);
    wr(msb(1'b0, 1'b0), 40'h_01_0000_0000, 2, 1'b0);
    chk("hs_sr", 1'b1, hs_mode);
    nvsi_master_model_i.stop();
    chk("hs_off", 1'b0, hs_mode);
    conclude();
  end
endmodule : nvsi_slave_tb_top
